//--- usp_master.sv
// Purpose: Master serial-peripheral mode of a serial unit, with AXI4-Lite
// Assumes: Inputs synchronous to mclk; the slave follows the sync clock
// Notes: Eight-bit frames, double buffered transmit, two-deep receive
//
// The implementer's own choice: register access over AXI4-Lite.
`default_nettype none
module usp_master
    import usp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_in_pin,
    output usp_pins_s pins
);
    logic [7:0] baud_divisor_low;
    logic [3:0] baud_divisor_high;
    logic [7:0] ctrl;
    logic [7:0] ena;
    logic [7:0] txbuf;
    logic txbuf_full;
    logic [7:0] rxq0;
    logic [7:0] rxq1;
    logic [1:0] rxcnt;
    logic txc;
    logic [7:0] txsh;
    logic [7:0] rxsh;
    logic [3:0] edges;
    logic sclk_lvl;
    usp_state_e state;
    logic aw_got, w_got;
    logic [31:0] aw_q, w_q;
    logic [3:0] ws_q;
    logic tick;
    usp_mode_s mode;
    logic wr_fire, rd_fire, data_wr, data_rd, div_lo_wr;
    logic [9:0] wa, ra;

    assign wa = aw_got ? aw_q[9:0] : s_axi_awaddr[9:0];
    assign ra = s_axi_araddr[9:0];
    // Write fires once both halves are held or offered and no response is pending
    assign wr_fire = (aw_got || s_axi_awvalid) && (w_got || s_axi_wvalid)
        && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign data_wr = wr_fire && wa == USP_ADDR_DATA && ws_eff()[0];
    assign data_rd = rd_fire && ra == USP_ADDR_DATA;
    assign div_lo_wr = wr_fire && wa == USP_ADDR_DIV_LO && ws_eff()[0];

    function automatic logic [3:0] ws_eff();
        return w_got ? ws_q : s_axi_wstrb;
    endfunction

    function automatic logic [7:0] wd_eff();
        return w_got ? w_q[7:0] : s_axi_wdata[7:0];
    endfunction

    // Mode bits decoded once; both select bits one means master mode
    // master mode select
    always_comb
    begin
        mode.pol = ctrl[USP_CTRL_POL];
        mode.pha = ctrl[USP_CTRL_PHA];
        mode.lsb_first = ctrl[USP_CTRL_ORD];
        mode.spi_mode = ctrl[USP_CTRL_MSEL1] & ctrl[USP_CTRL_MSEL0];
    end

    usp_baud u_baud (
        .mclk(mclk),
        .reset(reset),
        .divisor({baud_divisor_high, baud_divisor_low}),
        .reload(div_lo_wr),
        .run(state == USP_SHIFT),
        .tick(tick)
    );

    // Register writes and bus handshake state
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            baud_divisor_low <= 8'h00;
            baud_divisor_high <= 4'h0;
            ctrl <= USP_CTRL_RESET;
            ena <= 8'h00;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_q <= 32'h0;
            w_q <= 32'h0;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= USP_RESP_OK;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready && !wr_fire)
            begin
                aw_got <= 1'b1;
                aw_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_fire)
            begin
                w_got <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= USP_RESP_OK;
                // mode bits change with no frame guard
                // divisor change takes effect mid frame
                if (ws_eff()[0])
                begin
                    case (wa)
                        USP_ADDR_DIV_LO: baud_divisor_low <= wd_eff();
                        USP_ADDR_DIV_HI: baud_divisor_high <= wd_eff()[3:0];
                        USP_ADDR_CTRL: ctrl <= wd_eff();
                        USP_ADDR_ENA: ena <= wd_eff();
                        USP_ADDR_STAT, USP_ADDR_DATA: ;
                        default: s_axi_bresp <= USP_RESP_ERR;
                    endcase
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read channel: one read at a time, answer one cycle after address
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= USP_RESP_OK;
        end
        else if (rd_fire)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= USP_RESP_OK;
            s_axi_rdata <= 32'h0;
            case (ra)
                USP_ADDR_DIV_LO: s_axi_rdata[7:0] <= baud_divisor_low;
                USP_ADDR_DIV_HI: s_axi_rdata[3:0] <= baud_divisor_high;
                USP_ADDR_CTRL: s_axi_rdata[7:0] <= ctrl;
                USP_ADDR_ENA: s_axi_rdata[7:0] <= ena;
                USP_ADDR_STAT: s_axi_rdata[7:0] <= {rxcnt != 2'd0, txc,
                    !txbuf_full, 5'b00000};
                USP_ADDR_DATA: s_axi_rdata[7:0] <= rxq0;
                default: s_axi_rresp <= USP_RESP_ERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Common transfer control: one engine owns both shift registers
    // shared transfer control
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            state <= USP_IDLE;
            txbuf <= 8'h00;
            txbuf_full <= 1'b0;
            txsh <= 8'h00;
            rxsh <= 8'h00;
            edges <= 4'h0;
            sclk_lvl <= 1'b0;
            rxq0 <= 8'h00;
            rxq1 <= 8'h00;
            rxcnt <= 2'd0;
            txc <= 1'b0;
        end
        else
        begin
            if (data_wr && ena[USP_ENA_TX])
            begin
                txbuf <= wd_eff();
                txbuf_full <= 1'b1;
                txc <= 1'b0;
            end
            else if (wr_fire && wa == USP_ADDR_STAT && wd_eff()[USP_STAT_TXC])
            begin
                txc <= 1'b0;
            end
            if (data_rd && rxcnt != 2'd0)
            begin
                rxq0 <= rxq1;
                rxcnt <= rxcnt - 2'd1;
            end
            if (state == USP_IDLE)
            begin
                sclk_lvl <= mode.pol;
                if (txbuf_full && mode.spi_mode && !data_wr)
                begin
                    txsh <= txbuf;
                    txbuf_full <= 1'b0;
                    edges <= 4'h0;
                    state <= USP_SHIFT;
                end
            end
            else if (tick)
            begin
                sclk_lvl <= !sclk_lvl;
                edges <= edges + 4'h1;
                if (edges[0] == mode.pha)
                begin
                    rxsh <= mode.lsb_first ? {serial_in_pin, rxsh[7:1]}
                        : {rxsh[6:0], serial_in_pin};
                end
                // First setup edge in phase one only presents the first bit
                else if (edges != USP_LAST_EDGE && edges != 4'h0)
                begin
                    txsh <= mode.lsb_first ? {1'b0, txsh[7:1]}
                        : {txsh[6:0], 1'b0};
                end
                if (edges == USP_LAST_EDGE)
                begin
                    state <= USP_IDLE;
                    txc <= !txbuf_full;
                    // Overrun keeps the older bytes, the new one is lost
                    if (ena[USP_ENA_RX] && rxcnt != 2'd2)
                    begin
                        if (rxcnt == 2'd0 || (rxcnt == 2'd1 && data_rd))
                        begin
                            rxq0 <= mode.pha ? rx_last() : rxsh;
                        end
                        else
                        begin
                            rxq1 <= mode.pha ? rx_last() : rxsh;
                        end
                        rxcnt <= data_rd ? rxcnt : rxcnt + 2'd1;
                    end
                end
            end
        end
    end

    // Final sample lands on the last edge for phase one
    function automatic logic [7:0] rx_last();
        return mode.lsb_first ? {serial_in_pin, rxsh[7:1]}
            : {rxsh[6:0], serial_in_pin};
    endfunction

    // Pin outputs registered; pin drive follows enable and direction bits
    // clock pin driven when direction set
    // pin control same in all modes
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            pins <= '{sclk: 1'b0, sclk_oe_n: 1'b1, sdo: 1'b1, sdo_oe_n: 1'b1};
        end
        else
        begin
            pins.sclk <= sclk_lvl;
            pins.sclk_oe_n <= !ena[USP_ENA_XDIR];
            pins.sdo <= mode.lsb_first ? txsh[0] : txsh[7];
            pins.sdo_oe_n <= !ena[USP_ENA_TX];
        end
    end

    // Helpers for checks
    logic [12:0] gap;
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            gap <= 13'h0;
        end
        else
        begin
            // Idle time and reloads must not count toward a half period
            gap <= (tick || state == USP_IDLE || div_lo_wr) ? 13'h0
                : gap + 13'h1;
        end
    end

    sequence idle_s;
        state == USP_IDLE;
    endsequence

    idle_level_a: assert property (@(posedge mclk) disable iff (reset)
        idle_s ##1 (state == USP_IDLE && $stable(mode.pol))
        |-> sclk_lvl == mode.pol)
        else $error("idle clock level wrong");
    baud_gap_a: assert property (@(posedge mclk) disable iff (reset)
        tick && $past(tick) |-> {baud_divisor_high, baud_divisor_low} == 0)
        else $error("tick spacing wrong");
    gap_max_a: assert property (@(posedge mclk) disable iff (reset)
        state == USP_SHIFT && !div_lo_wr |-> gap <= 13'd4097)
        else $error("prescaler stalled");
    start_a: assert property (@(posedge mclk) disable iff (reset)
        idle_s and txbuf_full && mode.spi_mode && !data_wr
        |=> state == USP_SHIFT)
        else $error("transfer not started");
    toggle_a: assert property (@(posedge mclk) disable iff (reset)
        state == USP_SHIFT && tick |=> sclk_lvl != $past(sclk_lvl))
        else $error("clock did not toggle");
    flags_zero_a: assert property (@(posedge mclk) disable iff (reset)
        $past(rd_fire) && $past(ra) == USP_ADDR_STAT
        |-> s_axi_rdata[4:2] == 3'b000)
        else $error("error flags not zero");
    mode_gate_a: assert property (@(posedge mclk) disable iff (reset)
        idle_s and !mode.spi_mode |=> state == USP_IDLE)
        else $error("shift outside master mode");
    frame_end_a: assert property (@(posedge mclk) disable iff (reset)
        state == USP_SHIFT && tick && edges == USP_LAST_EDGE
        |=> state == USP_IDLE)
        else $error("frame length wrong");
endmodule
`default_nettype wire

//--- usp_pkg.sv
// Purpose: Shared constants and types for the master serial clocking block
// Assumes: 32-bit AXI4-Lite register bus, one clock at 50 MHz
// Notes: Offsets are kept as register indices; byte address is index times 4
`default_nettype none
package usp_pkg;
    localparam int USP_CLK_HZ = 50000000;
    // Register indices as printed, and derived byte addresses
    localparam logic [7:0] USP_IDX_DIV_LO = 8'hC4;
    localparam logic [7:0] USP_IDX_DIV_HI = 8'hC5;
    localparam logic [7:0] USP_IDX_CTRL = 8'hC2;
    localparam logic [7:0] USP_IDX_ENA = 8'hC1;
    localparam logic [7:0] USP_IDX_STAT = 8'hC0;
    localparam logic [7:0] USP_IDX_DATA = 8'hC6;
    localparam logic [9:0] USP_ADDR_DIV_LO = {USP_IDX_DIV_LO, 2'b00};
    localparam logic [9:0] USP_ADDR_DIV_HI = {USP_IDX_DIV_HI, 2'b00};
    localparam logic [9:0] USP_ADDR_CTRL = {USP_IDX_CTRL, 2'b00};
    localparam logic [9:0] USP_ADDR_ENA = {USP_IDX_ENA, 2'b00};
    localparam logic [9:0] USP_ADDR_STAT = {USP_IDX_STAT, 2'b00};
    localparam logic [9:0] USP_ADDR_DATA = {USP_IDX_DATA, 2'b00};
    // Control register fields
    localparam int USP_CTRL_POL = 0;
    localparam int USP_CTRL_PHA = 1;
    localparam int USP_CTRL_ORD = 2;
    localparam int USP_CTRL_MSEL0 = 6;
    localparam int USP_CTRL_MSEL1 = 7;
    localparam logic [7:0] USP_CTRL_RESET = 8'h06;
    // Enable register fields
    localparam int USP_ENA_TX = 3;
    localparam int USP_ENA_RX = 4;
    localparam int USP_ENA_XDIR = 5;
    // Status register fields
    localparam int USP_STAT_PE = 2;
    localparam int USP_STAT_DOR = 3;
    localparam int USP_STAT_FE = 4;
    localparam int USP_STAT_DRE = 5;
    localparam int USP_STAT_TXC = 6;
    localparam int USP_STAT_RXC = 7;
    localparam int USP_DIV_W = 12;
    localparam int USP_FRAME_BITS = 8;
    localparam logic [3:0] USP_LAST_EDGE = 4'hF;
    localparam logic [1:0] USP_RESP_OK = 2'b00;
    localparam logic [1:0] USP_RESP_ERR = 2'b10;

    typedef enum logic [1:0] {USP_IDLE, USP_SHIFT} usp_state_e;

    // Serial pins grouped as they leave the block
    typedef struct packed {
        logic sclk;
        logic sclk_oe_n;
        logic sdo;
        logic sdo_oe_n;
    } usp_pins_s;

    typedef struct packed {
        logic pol;
        logic pha;
        logic lsb_first;
        logic spi_mode;
    } usp_mode_s;
endpackage
`default_nettype wire

//--- usp_baud.sv
// Purpose: Baud prescaler giving one enable per half sync-clock period
// Assumes: Divisor 0..4095, reload pulse from a low-byte write
// Notes: Period is divisor+1 system clocks per half bit
`default_nettype none
module usp_baud
    import usp_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [USP_DIV_W-1:0] divisor,
    input wire logic reload,
    input wire logic run,
    output logic tick
);
    logic [USP_DIV_W-1:0] count;
    logic [USP_DIV_W-1:0] next_count;
    logic next_tick;

    // Count down, tick on expiry; reload restarts the count at once
    always_comb
    begin
        next_count = count;
        next_tick = 1'b0;
        if (reload || !run)
        begin
            next_count = divisor;
        end
        else if (count == '0)
        begin
            next_count = divisor;
            next_tick = 1'b1;
        end
        else
        begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule
`default_nettype wire

//--- usp_slave_model.sv
// Purpose: Behavioural serial slave clocked by the master sync clock
// Assumes: No select line; the bench arms it only around real frames
// Notes: Reply bit moves on setup edges, capture on sample edges
`default_nettype none
module usp_slave_model
    import usp_pkg::*;
(
    input wire logic sclk,
    input wire logic sdo,
    input wire logic arm,
    input wire logic pol,
    input wire logic pha,
    input wire logic lsb,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got,
    output logic [7:0] cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    int si = 0;
    int oi = 0;
    logic [7:0] sh = 8'h00;
    logic bitv;

    // Reply bit in the chosen order; inverted while not armed
    // order both ways
    assign bitv = lsb ? reply[oi[2:0]] : reply[3'h7 - oi[2:0]];
    assign miso = arm ? bitv : ~bitv;

    // Bit positions restart whenever the bench reconfigures the link; got and cnt never do
    initial
    begin
        got = 8'h00;
        cnt = 8'h00;
    end
    always @(negedge arm)
    begin
        si = 0;
        oi = 0;
    end

    // Edge away from idle level is leading; phase picks the sample edge
    // mode edge choice
    always @(sclk)
    begin
        if (arm && ((sclk != pol) ^ pha))
        begin
            sh[lsb ? si : 7 - si] = sdo;
            if (si == 7)
            begin
                got = sh;
                cnt = cnt + 8'h01;
            end
            si = (si + 1) % 8;
        end
        else if (arm)
            oi = si;
    end
endmodule
`default_nettype wire

//--- usp_master_tb_top.sv
// Purpose: Self-checking bench for the master serial clocking block
// Assumes: Slave model on the far side, AXI4-Lite tasks reach registers
// Notes: Divisors stay at 2 or more so the slave reply never races
`default_nettype none
module usp_master_tb_top
    import usp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0;
    logic reset = 1'h1;
    logic [31:0] awaddr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] araddr = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, miso;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    usp_pins_s pins;
    logic arm = 1'h0;
    logic pol = 1'h0;
    logic pha = 1'h0;
    logic lsb = 1'h0;
    logic [7:0] reply = 8'h00;
    logic [7:0] got, cnt, c0;
    logic sclk_d = 1'h0;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    int tcnt = 0;
    int last_e = 0;
    int gap_min = 999;
    int m, n;

    always #10ns mclk = ~mclk;

    usp_master dut_u (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_in_pin(miso), .pins(pins));

    usp_slave_model slave_u (.sclk(pins.sclk), .sdo(pins.sdo), .arm(arm),
        .pol(pol), .pha(pha), .lsb(lsb), .reply(reply), .miso(miso),
        .got(got), .cnt(cnt));

    // Shortest sync clock half period seen since the last clear
    always @(posedge mclk)
    begin
        tcnt++;
        if (pins.sclk !== sclk_d)
        begin
            if (tcnt - last_e < gap_min)
                gap_min = tcnt - last_e;
            last_e = tcnt;
        end
        sclk_d = pins.sclk;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("BAD t=%0t timeout", $time);
            end_sim;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
        input string s);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask

    // Write: address and data offered together, each dropped when taken
    task automatic wr(input logic [9:0] a, input logic [7:0] v,
        input logic [1:0] er);
        @(posedge mclk);
        awaddr <= {22'h0, a};
        wdata <= {24'h0, v};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever
        begin
            @(posedge mclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
            begin
                bready <= 1'h0;
                chk({30'h0, bresp}, {30'h0, er}, "write response");
                break;
            end
        end
    endtask

    task automatic rd(input logic [9:0] a, input logic [1:0] er,
        output logic [31:0] v);
        @(posedge mclk);
        araddr <= {22'h0, a};
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever
        begin
            @(posedge mclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
            begin
                v = rdata;
                rready <= 1'h0;
                chk({30'h0, rresp}, {30'h0, er}, "read response");
                break;
            end
        end
    endtask

    // One frame in a given mode, order and divisor, both directions
    task automatic xfer(input logic p, input logic h, input logic o,
        input logic [7:0] dv, input logic [7:0] tx, input logic [7:0] rp);
        arm <= 1'h0;
        pol <= p;
        pha <= h;
        lsb <= o;
        reply <= rp;
        wr(USP_ADDR_CTRL, {2'h3, 3'h0, o, h, p}, USP_RESP_OK);
        wr(USP_ADDR_DIV_LO, dv, USP_RESP_OK);
        repeat (4) @(posedge mclk);
        chk({31'h0, pins.sclk}, {31'h0, p}, "idle level");
        arm <= 1'h1;
        gap_min = 999;
        wr(USP_ADDR_DATA, tx, USP_RESP_OK);
        d = 32'h0;
        for (n = 0; n < 300 && d[7] !== 1'h1; n++)
            rd(USP_ADDR_STAT, USP_RESP_OK, d);
        chk(d & 32'h1C, 32'h0, "error flags");
        rd(USP_ADDR_DATA, USP_RESP_OK, d);
        chk(d, {24'h0, rp}, "byte from slave");
        chk({24'h0, got}, {24'h0, tx}, "byte to slave");
        chk(gap_min, {24'h0, dv} + 32'h1, "half period");
        chk({31'h0, pins.sclk}, {31'h0, p}, "idle after");
        $display("test mode %0d order %0d done", {p, h}, o);
    endtask

    initial
    begin
        repeat (10) @(posedge mclk);
        reset <= 1'h0;
        rd(USP_ADDR_DIV_LO, USP_RESP_OK, d);
        chk(d, 32'h0, "low divisor reset");
        rd(USP_ADDR_DIV_HI, USP_RESP_OK, d);
        chk(d, 32'h0, "high divisor reset");
        rd(USP_ADDR_CTRL, USP_RESP_OK, d);
        chk(d, {24'h0, USP_CTRL_RESET}, "control reset");
        wr(USP_ADDR_DIV_HI, 8'hFF, USP_RESP_OK);
        rd(USP_ADDR_DIV_HI, USP_RESP_OK, d);
        chk(d, 32'h0F, "high divisor width");
        wr(USP_ADDR_DIV_HI, 8'h00, USP_RESP_OK);
        wr(10'h3FC, 8'h55, USP_RESP_ERR);
        rd(10'h3FC, USP_RESP_ERR, d);
        $display("test registers done");
        // Clock pin direction first, then enable both directions
        wr(USP_ADDR_ENA, 8'h20, USP_RESP_OK);
        repeat (2) @(posedge mclk);
        chk({31'h0, pins.sclk_oe_n}, 32'h0, "clock pin drive");
        wr(USP_ADDR_ENA, 8'h38, USP_RESP_OK);
        repeat (2) @(posedge mclk);
        chk({31'h0, pins.sdo_oe_n}, 32'h0, "data pin drive");
        for (m = 0; m < 8; m++)
            xfer(m[0], m[1], m[2], m[2] ? 8'h05 : 8'h02, 8'hA5 ^ m[7:0],
                8'h3C + m[7:0]);
        // Two writes back to back: second waits in the buffer
        c0 = cnt;
        wr(USP_ADDR_DATA, 8'h11, USP_RESP_OK);
        wr(USP_ADDR_DATA, 8'h22, USP_RESP_OK);
        for (n = 0; n < 2000 && cnt !== c0 + 8'h02; n++)
            @(posedge mclk);
        chk({24'h0, cnt - c0}, 32'h2, "frames sent");
        chk({24'h0, got}, 32'h22, "second byte");
        rd(USP_ADDR_DATA, USP_RESP_OK, d);
        chk(d, {24'h0, reply}, "first reply");
        rd(USP_ADDR_DATA, USP_RESP_OK, d);
        chk(d, {24'h0, reply}, "second reply");
        $display("test double buffer done");
        end_sim;
    end
endmodule
`default_nettype wire
